/* File: lvdc_pkg.sv */
//==================================================================
// Overview of operation
// - Control bits 7:6 read zero, ignore writes.
// - Control bit 4 powers and enables monitor.
// - Comparator and divider powered only while enabled.
// - Bits 3:0 select level; 1111 reserved.
// - Level drives one of fifteen divider taps.
// - Bit 5 read-only, set once reference settled.
// - No trip sets the flag before reference is stable.
// - Settling is fixed time, excursions may escape.
// - Enabled stable comparator trip sets flag.
// - Shared reference restarts only when all users off.
// - Flag re-sets while supply stays past trip.
// - Monitor keeps running in sleep and wakes.
// - Reset returns control register, monitor off.
package lvdc_pkg;

  //==================================================================
  // Register bus shape and offsets.
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 8;
  localparam logic [2:0]  OFF_CTRL     = 3'h0;
  localparam logic [2:0]  OFF_FLAG     = 3'h1;
  localparam logic [2:0]  OFF_FEN      = 3'h2;
  localparam logic [2:0]  OFF_EVT      = 3'h3;
  localparam logic [2:0]  OFF_EMSK     = 3'h4;

  //==================================================================
  // Field positions and reset values.
  localparam int          CTL_STB_BIT  = 5;
  localparam int          CTL_EN_BIT   = 4;
  localparam int          FLAG_BIT     = 2;
  localparam int          EVT_TRIP     = 0;
  localparam int          EVT_STABLE   = 1;
  localparam logic [3:0]  LVL_RST      = 4'h5;
  localparam logic [3:0]  LVL_MAX      = 4'he;
  localparam logic [3:0]  LVL_RSVD     = 4'hf;

  //==================================================================
  // Reference settling time and its cycle count.
  localparam int          CLK_KHZ      = 20000;
  localparam int          SETTLE_NS    = 20000;
  localparam int          SETTLE_CYC   = (SETTLE_NS * CLK_KHZ + 999999) / 1000000;

  // Settling sequencer states.
  typedef enum logic [1:0] {
    LVDC_REF_OFF    = 2'b00,
    LVDC_REF_SETTLE = 2'b01,
    LVDC_REF_STABLE = 2'b10
  } lvdc_ref_state_t;

endpackage

/* File: lvdc_ref_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Request for the shared reference and its settled answer.
interface lvdc_ref_if;
  logic req;
  logic stable;
  modport ctl    (output req, input stable);
  modport settle (input req, output stable);
endinterface
`default_nettype wire

/* File: lvdc_settle.sv */
`timescale 1ns/10ps
`default_nettype none
module lvdc_settle
  import lvdc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      other_user,
  lvdc_ref_if.settle     rif
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  lvdc_ref_state_t state_r;
  logic [CW-1:0]   cnt_r;
  logic            ref_on;

  initial begin
    if (SETTLE_CYCLES < 1) begin
      $error("Settling count must be at least one cycle.");
    end
  end

  // The reference runs while any of its users wants it.
  assign ref_on = rif.req | other_user;

  //==================================================================
  // Settling sequencer: restarts only from a fully idle reference.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= LVDC_REF_OFF;
      cnt_r   <= '0;
    end else if (!ref_on) begin
      state_r <= LVDC_REF_OFF;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        LVDC_REF_OFF: begin
          state_r <= LVDC_REF_SETTLE;
          cnt_r   <= '0;
        end
        LVDC_REF_SETTLE: begin
          if (cnt_r == CW'(SETTLE_CYCLES - 1)) begin
            state_r <= LVDC_REF_STABLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        LVDC_REF_STABLE: state_r <= LVDC_REF_STABLE;
        default:         state_r <= LVDC_REF_OFF;
      endcase
    end
  end

  assign rif.stable = (state_r == LVDC_REF_STABLE);

  //==================================================================
  // Checks on the settling sequencer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  settle_len_a: assert property ($rose(rif.stable) |-> $past(cnt_r) == CW'(SETTLE_CYCLES - 1))
    else $error("Reference stable before settling count ran out.");
  shared_keep_a: assert property (rif.stable && other_user |=> rif.stable)
    else $error("Reference restarted while another user held it.");

endmodule
`default_nettype wire

/* File: lvdc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module lvdc_top
  import lvdc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  input  wire logic              supply_trip,
  input  wire logic              bor_ref_user,
  input  wire logic              sleep_mode,
  output var  logic              comparator_power,
  output var  logic              divider_power,
  output var  logic [3:0]        tap_select,
  output var  logic              irq,
  output var  logic              wake_req
);

  //==================================================================
  // Elaboration checks.
  // A zero settling count would raise the stable bit in the very cycle
  // that the monitor is enabled, so such a count is refused.
  initial begin
    if (SETTLE_CYCLES < 1) begin
      $error("Settling count must be at least one cycle.");
    end
  end

  //==================================================================
  // Decoding helpers.

  // True when a strobe addresses the given register.
  function automatic logic reg_hit(input logic stb, input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = stb && (a == off);
  endfunction

  // Maps the level field onto a usable divider tap.
  // Code 1111 has no tap of its own, so the top tap stands in for it
  // and the divider never sees an undefined select.
  function automatic logic [3:0] tap_of(input logic [3:0] lvl);
    tap_of = (lvl == LVL_RSVD) ? LVL_MAX : lvl;
  endfunction

  //==================================================================
  // State.
  logic              monitor_power_enable_r;
  logic [3:0]        trip_level_select_r;
  logic              low_supply_flag_r;
  logic              low_supply_irq_enable_r;
  logic [1:0]        evt_r;
  logic [1:0]        emsk_r;
  logic              stable_d_r;
  logic              low_supply_flag_nxt;
  logic [1:0]        evt_nxt;
  logic              reference_stable_flag;
  logic              set_cond;
  logic              wr_ctrl;
  logic              wr_flag;
  logic              wr_fen;
  logic              wr_emsk;
  logic              rd_evt;
  logic [DATA_W-1:0] rd_val;

  lvdc_ref_if rif ();

  //==================================================================
  // Shared reference and its settling sequencer.
  // The brown-out user shares the sequencer, so the reference may stay
  // up and settled while this monitor is switched off.
  assign rif.req = monitor_power_enable_r;

  lvdc_settle #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk        (clk),
    .rst_n      (rst_n),
    .other_user (bor_ref_user),
    .rif        (rif)
  );

  // Stable bit reads zero whenever this monitor is off.
  // It therefore drops in the cycle after software clears the enable.
  assign reference_stable_flag = monitor_power_enable_r & rif.stable;

  //==================================================================
  // Strobe decode.
  // Each strobe counts only at its own offset; unmapped offsets hit nothing.
  assign wr_ctrl = reg_hit(reg_wr, reg_addr, OFF_CTRL);
  assign wr_flag = reg_hit(reg_wr, reg_addr, OFF_FLAG);
  assign wr_fen  = reg_hit(reg_wr, reg_addr, OFF_FEN);
  assign wr_emsk = reg_hit(reg_wr, reg_addr, OFF_EMSK);
  assign rd_evt  = reg_hit(reg_rd, reg_addr, OFF_EVT);

  //==================================================================
  // Control register: enable and level only; bits 7:5 drop on write.
  // The stable bit is not stored here; it is rebuilt for every read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      monitor_power_enable_r <= 1'b0;
      trip_level_select_r    <= LVL_RST;
    end else if (wr_ctrl) begin
      monitor_power_enable_r <= reg_wdata[CTL_EN_BIT];
      trip_level_select_r    <= reg_wdata[3:0];
    end
  end

  //==================================================================
  // Analog controls follow the enable and the level field.
  // Both analog parts switch with the enable flop itself, so they stay
  // off from reset until software asks for them.
  assign comparator_power = monitor_power_enable_r;
  assign divider_power    = monitor_power_enable_r;

  // Tap register keeps the reserved code off the divider.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tap_select <= tap_of(LVL_RST);
    end else begin
      tap_select <= tap_of(trip_level_select_r);
    end
  end

  //==================================================================
  // Low-supply flag: a trip only counts once the reference settled,
  // and a set in the cycle of a clearing write still wins.
  // A written one sets the flag too, so software can try the interrupt
  // path without a real supply dip.
  assign set_cond = reference_stable_flag & supply_trip;

  always_comb begin
    low_supply_flag_nxt = wr_flag ? reg_wdata[FLAG_BIT] : low_supply_flag_r;
    if (set_cond) begin
      low_supply_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_supply_flag_r <= 1'b0;
    end else begin
      low_supply_flag_r <= low_supply_flag_nxt;
    end
  end

  // Flag enable register.
  // Only bit 2 is kept, in the same place as the flag that it gates.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_supply_irq_enable_r <= 1'b0;
    end else if (wr_fen) begin
      low_supply_irq_enable_r <= reg_wdata[FLAG_BIT];
    end
  end

  //==================================================================
  // Event status: trip and reference-ready events, cleared by a read.
  // The trip event marks a new rise of the flag, not a standing trip,
  // so a supply that stays low does not refill the register after a read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stable_d_r <= 1'b0;
    end else begin
      stable_d_r <= reference_stable_flag;
    end
  end

  always_comb begin
    evt_nxt = rd_evt ? 2'b00 : evt_r;
    if (set_cond && !low_supply_flag_r) begin
      evt_nxt[EVT_TRIP] = 1'b1;
    end
    if (reference_stable_flag && !stable_d_r) begin
      evt_nxt[EVT_STABLE] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evt_r <= 2'b00;
    end else begin
      evt_r <= evt_nxt;
    end
  end

  // Event mask register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      emsk_r <= 2'b00;
    end else if (wr_emsk) begin
      emsk_r <= reg_wdata[1:0];
    end
  end

  //==================================================================
  // Interrupt and wake outputs.
  // Both are registered and so lag their sources by one cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (low_supply_flag_r & low_supply_irq_enable_r) | (|(evt_r & emsk_r));
    end
  end

  // The flag wakes a sleeping device whether or not interrupts are on.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= sleep_mode & low_supply_flag_r;
    end
  end

  //==================================================================
  // Read mux; unmapped offsets read zero.
  // Reserved bits are tied low here rather than stored.
  always_comb begin
    case (reg_addr)
      OFF_CTRL: rd_val = {2'b00, reference_stable_flag, monitor_power_enable_r,
                          trip_level_select_r};
      OFF_FLAG: rd_val = {5'h00, low_supply_flag_r, 2'b00};
      OFF_FEN:  rd_val = {5'h00, low_supply_irq_enable_r, 2'b00};
      OFF_EVT:  rd_val = {6'h00, evt_r};
      OFF_EMSK: rd_val = {6'h00, emsk_r};
      default:  rd_val = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
    end
  end

  //==================================================================
  // Checks. They watch the register state and the outputs that this
  // module drives, and stay quiet while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The monitor is on and its reference has settled.
  sequence s_armed;
    monitor_power_enable_r && rif.stable;
  endsequence

  // A trip reported while the monitor is armed.
  sequence s_trip;
    s_armed ##0 supply_trip;
  endsequence

  // The monitor is switched on while its reference is idle.
  sequence s_cold_enable;
    wr_ctrl && reg_wdata[CTL_EN_BIT] && !monitor_power_enable_r && !bor_ref_user;
  endsequence

  // Software writes zero to the flag.
  sequence s_clear_wr;
    wr_flag && !reg_wdata[FLAG_BIT];
  endsequence

  rsvd_bits_a: assert property (reg_hit(reg_rd, reg_addr, OFF_CTRL) |=> reg_rdata[7:6] == 2'b00)
    else $error("Control bits 7:6 did not read zero.");
  en_write_a: assert property (wr_ctrl |=> monitor_power_enable_r == $past(reg_wdata[CTL_EN_BIT]))
    else $error("Enable did not take the written value.");
  power_off_a: assert property (wr_ctrl && !reg_wdata[CTL_EN_BIT] |=> !comparator_power && !divider_power)
    else $error("Analog parts stayed powered after disable.");
  tap_map_a: assert property (wr_ctrl |=> ##1 tap_select == (($past(reg_wdata[3:0], 2) == LVL_RSVD)
                                                       ? LVL_MAX : $past(reg_wdata[3:0], 2)))
    else $error("Divider tap does not follow the level field.");
  stable_ro_a: assert property (wr_ctrl && reg_wdata[CTL_STB_BIT] && !monitor_power_enable_r && !bor_ref_user
                                |=> !reference_stable_flag)
    else $error("Stable bit was set by a write.");
  early_flag_a: assert property ($rose(low_supply_flag_r) && !$past(wr_flag) |-> $past(reference_stable_flag))
    else $error("Flag set before the reference settled.");
  trip_sets_a: assert property (s_trip |=> low_supply_flag_r)
    else $error("Trip on armed monitor did not set the flag.");
  reset_again_a: assert property (s_trip ##0 s_clear_wr |=> low_supply_flag_r)
    else $error("Clear won over a standing trip.");
  wake_a: assert property (sleep_mode && low_supply_flag_r |=> wake_req)
    else $error("Flag during sleep did not wake the device.");
  flag_hold_a: assert property (low_supply_flag_r && !wr_flag |=> low_supply_flag_r)
    else $error("Flag dropped without a clearing write.");
  off_stable_a: assert property (reg_hit(reg_rd, reg_addr, OFF_CTRL) && !monitor_power_enable_r
                                 |=> !reg_rdata[CTL_STB_BIT])
    else $error("Stable bit read one while disabled.");

  // Further checks on the control register. A power enable must reach
  // both analog parts in one cycle, the reserved level must never reach
  // the divider, and a control read must show the stored level.
  power_on_a: assert property (wr_ctrl && reg_wdata[CTL_EN_BIT] |=> comparator_power && divider_power)
    else $error("Analog parts stayed off after enable.");
  tap_rsvd_a: assert property (wr_ctrl && reg_wdata[3:0] == LVL_RSVD |=> ##1 tap_select == LVL_MAX)
    else $error("Reserved level code reached the divider.");
  level_read_a: assert property (reg_hit(reg_rd, reg_addr, OFF_CTRL) |=> reg_rdata[3:0] == $past(trip_level_select_r))
    else $error("Level field read back wrong.");

  // Settling checks. Switching on from an idle reference must hold the
  // stable bit low for the next two cycles, switching off must drop it at
  // once, and each rise of the bit must leave an event behind.
  settle_wait_a: assert property (s_cold_enable |=> (!reference_stable_flag) [*2])
    else $error("Stable bit rose without a fresh settling interval.");
  stable_off_a: assert property (wr_ctrl && !reg_wdata[CTL_EN_BIT] |=> !reference_stable_flag)
    else $error("Stable bit stayed high after disable.");
  stable_evt_a: assert property ($rose(reference_stable_flag) |=> evt_r[EVT_STABLE])
    else $error("Stable rise left no event.");
  stable_read_a: assert property (reg_hit(reg_rd, reg_addr, OFF_CTRL) |=> reg_rdata[CTL_STB_BIT] == $past(reference_stable_flag))
    else $error("Stable bit read back wrong.");

  // Flag checks. A clearing write works only when no trip stands, the
  // flag cannot move while the reference is unsettled unless software
  // writes it, and a flag read shows the flag of the strobe cycle.
  trip_evt_a: assert property (s_trip ##0 !low_supply_flag_r |=> evt_r[EVT_TRIP])
    else $error("Fresh trip left no event.");
  flag_clear_a: assert property (s_clear_wr ##0 !set_cond |=> !low_supply_flag_r)
    else $error("Clearing write did not clear the flag.");
  trip_idle_a: assert property (!reference_stable_flag && !wr_flag |=> low_supply_flag_r == $past(low_supply_flag_r))
    else $error("Flag moved while the reference was unsettled.");
  flag_read_a: assert property (reg_hit(reg_rd, reg_addr, OFF_FLAG) |=> reg_rdata[FLAG_BIT] == $past(low_supply_flag_r))
    else $error("Flag read back wrong.");

  // Interrupt and wake checks. The interrupt follows its enabled
  // sources one cycle late, and a wake request needs sleep.
  irq_flag_a: assert property (low_supply_flag_r && low_supply_irq_enable_r |=> irq)
    else $error("Enabled flag raised no interrupt.");
  irq_quiet_a: assert property (!low_supply_irq_enable_r && !(|(evt_r & emsk_r)) |=> !irq)
    else $error("Interrupt without an enabled source.");
  fen_write_a: assert property (wr_fen |=> low_supply_irq_enable_r == $past(reg_wdata[FLAG_BIT]))
    else $error("Flag enable did not take the written value.");
  wake_quiet_a: assert property (!sleep_mode |=> !wake_req)
    else $error("Wake request outside sleep.");

endmodule
`default_nettype wire

/* File: lvdc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module lvdc_top_tb;
  import lvdc_pkg::*;
  //==================================================================
  // Stimulus and observation signals.
  localparam int    SC = 4;
  logic             clk = 1'b0;
  logic             rst_n;
  logic [2:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic             supply_trip;
  logic             bor_ref_user;
  logic             sleep_mode;
  logic             comparator_power;
  logic             divider_power;
  logic [3:0]       tap_select;
  logic             irq;
  logic             wake_req;
  int               bad_count = 0;
  int               check_count = 0;

  // A short settle count keeps the run brief.
  lvdc_top #(.SETTLE_CYCLES(SC)) u_lvdc_top (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_trip(supply_trip), .bor_ref_user(bor_ref_user), .sleep_mode(sleep_mode),
    .comparator_power(comparator_power), .divider_power(divider_power),
    .tap_select(tap_select), .irq(irq), .wake_req(wake_req)
  );

  //==================================================================
  // Clock generation.
  initial begin
    forever #25 clk = ~clk;
  end

  // Compares a seen value against the expected one.
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One register write, then one idle edge.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // One register read; data is sampled mid-cycle after the strobe.
  task automatic rdchk(input string nm, input logic [2:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(nm, reg_rdata, exp);
    @(posedge clk);
  endtask

  // Waits n edges and then moves to the middle of the cycle.
  task automatic mid(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  //==================================================================
  // Scenarios.
  task automatic t_reset;
    rdchk("ctrl_rst", OFF_CTRL, 8'h05);
    mid(0);
    chk("power_rst", {6'h0, comparator_power, divider_power}, 8'h00);
    chk("tap_rst", {4'h0, tap_select}, 8'h05);
    @(posedge clk);
    wr(3'h5, 8'hff);
    rdchk("unmapped", 3'h5, 8'h00);
    rdchk("emsk_unmapped", OFF_EMSK, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_enable;
    supply_trip <= 1'b1;
    wr(OFF_CTRL, 8'h0f);
    wr(OFF_CTRL, 8'hff);
    rdchk("ctrl_ro", OFF_CTRL, 8'h1f);
    rdchk("flag_early", OFF_FLAG, 8'h00);
    mid(0);
    chk("power_on", {6'h0, comparator_power, divider_power}, 8'h03);
    chk("tap_rsvd", {4'h0, tap_select}, 8'h0e);
    @(posedge clk);
    repeat (SC + 6) @(posedge clk);
    rdchk("ctrl_stable", OFF_CTRL, 8'h3f);
    rdchk("flag_trip", OFF_FLAG, 8'h04);
    rdchk("events", OFF_EVT, 8'h03);
    rdchk("events_clr", OFF_EVT, 8'h00);
    $display("test enable done");
  endtask

  task automatic t_flag;
    wr(OFF_FLAG, 8'h00);
    wr(OFF_FEN, 8'h04);
    mid(1);
    chk("irq_on", {7'h0, irq}, 8'h01);
    @(posedge clk);
    wr(OFF_FEN, 8'h00);
    mid(1);
    chk("irq_off", {7'h0, irq}, 8'h00);
    @(posedge clk);
    wr(OFF_FLAG, 8'h00);
    rdchk("flag_reset", OFF_FLAG, 8'h04);
    supply_trip <= 1'b0;
    wr(OFF_FLAG, 8'h00);
    rdchk("flag_clr", OFF_FLAG, 8'h00);
    rdchk("flag_held", OFF_FLAG, 8'h00);
    $display("test flag done");
  endtask

  task automatic t_levels;
    for (int i = 0; i < 16; i++) begin
      wr(OFF_CTRL, 8'h10 | 8'(i));
      mid(1);
      chk("tap", {4'h0, tap_select}, (i == 15) ? 8'h0e : 8'(i));
      @(posedge clk);
    end
    $display("test levels done");
  endtask

  task automatic t_restart;
    wr(OFF_CTRL, 8'h05);
    mid(1);
    chk("power_off", {6'h0, comparator_power, divider_power}, 8'h00);
    @(posedge clk);
    rdchk("ctrl_off", OFF_CTRL, 8'h05);
    rdchk("events_old", OFF_EVT, 8'h00);
    wr(OFF_EMSK, 8'h02);
    wr(OFF_CTRL, 8'h15);
    rdchk("ctrl_settling", OFF_CTRL, 8'h15);
    repeat (SC + 6) @(posedge clk);
    rdchk("ctrl_resettled", OFF_CTRL, 8'h35);
    mid(0);
    chk("irq_evt", {7'h0, irq}, 8'h01);
    @(posedge clk);
    rdchk("events_stb", OFF_EVT, 8'h02);
    mid(1);
    chk("irq_evt_clr", {7'h0, irq}, 8'h00);
    @(posedge clk);
    wr(OFF_EMSK, 8'h00);
    wr(OFF_CTRL, 8'h05);
    bor_ref_user <= 1'b1;
    repeat (SC + 6) @(posedge clk);
    wr(OFF_CTRL, 8'h15);
    rdchk("ctrl_shared", OFF_CTRL, 8'h35);
    bor_ref_user <= 1'b0;
    $display("test restart done");
  endtask

  task automatic t_sleep;
    sleep_mode <= 1'b1;
    mid(2);
    chk("wake_idle", {7'h0, wake_req}, 8'h00);
    @(posedge clk);
    supply_trip <= 1'b1;
    mid(3);
    chk("wake_trip", {7'h0, wake_req}, 8'h01);
    @(posedge clk);
    rdchk("events_sleep", OFF_EVT, 8'h03);
    supply_trip <= 1'b0;
    sleep_mode  <= 1'b0;
    rst_n       <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl_midrst", OFF_CTRL, 8'h05);
    rdchk("flag_midrst", OFF_FLAG, 8'h00);
    mid(0);
    chk("power_midrst", {6'h0, comparator_power, divider_power}, 8'h00);
    $display("test sleep and reset done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //==================================================================
  // Main sequence.
  initial begin
    rst_n        = 1'b0;
    reg_addr     = 3'h0;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    supply_trip  = 1'b0;
    bor_ref_user = 1'b0;
    sleep_mode   = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_flag();
    t_levels();
    t_restart();
    t_sleep();
    end_sim();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
